//--- design/lmc_pkg.sv
/*
 lmc_pkg: frame codes, field positions, reset values and helper functions
 shared by both ends of the motion command link.
 assumes: one byte per cycle on the link, identifier byte first.
*/
`default_nettype none
package lmc_pkg;
   localparam logic [7:0]  LMC_SLEEP_ID   = 8'h3C;
   localparam logic [7:0]  LMC_SLEEP_B1   = 8'h00;
   localparam logic [7:0]  LMC_FILL       = 8'hFF;
   localparam logic [7:0]  LMC_STOP_CMD   = 8'h8F;
   localparam logic [1:0]  LMC_HALF_STEP  = 2'h0;
   localparam logic [10:0] LMC_NO_SECONDARY_POSITION  = 11'h400;
   localparam logic [10:0] LMC_POS_RST    = 11'h000;
   localparam int          LMC_GOTO_LEN   = 8;
   localparam int          LMC_STOP_LEN   = 2;
   localparam int          LMC_MARK_BIT   = 4;
   localparam int          LMC_BROAD_BIT  = 7;
   // commander registers (byte addresses)
   localparam logic [7:0]  LMC_CTRL_OFS   = 8'h00;
   localparam logic [7:0]  LMC_TAG_OFS    = 8'h04;
   localparam logic [7:0]  LMC_LO_OFS     = 8'h08;
   localparam logic [7:0]  LMC_HI_OFS     = 8'h0C;
   localparam logic [7:0]  LMC_STAT_OFS   = 8'h10;
   localparam logic [31:0] LMC_REG_RST    = 32'h0000_0000;
   localparam int          LMC_GO_BIT     = 2;

   typedef enum logic [1:0] {
      LMC_K_GOTO  = 2'b00,
      LMC_K_SLEEP = 2'b01,
      LMC_K_STOP  = 2'b10
   } lmc_kind_t;

   // protected identifier: parity over the six low bits
   function automatic logic [7:0] lmc_tag(input logic [5:0] t);
      logic p0;
      logic p1;
      p0 = t[0] ^ t[1] ^ t[2] ^ t[4];
      p1 = ~(t[1] ^ t[3] ^ t[4] ^ t[5]);
      return {p1, p0, t};
   endfunction

   // add with end-around carry, as the frame checksum does
   function automatic logic [7:0] lmc_add(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction
endpackage
`default_nettype wire

//--- design/lmc_link_if.sv
/*
 lmc_link_if: byte-wide command frame link between commander and responder.
 assumes: commander drives, responder always accepts; one clock hclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface lmc_link_if;
   logic       frm_valid;
   logic       frm_first;
   logic       frm_last;
   logic [7:0] frm_byte;
   modport commander (output frm_valid, output frm_first, output frm_last, output frm_byte);
   modport responder (input frm_valid, input frm_first, input frm_last, input frm_byte);
endinterface
`default_nettype wire

//--- design/lmc_responder.sv
/*
 lmc_responder: device end; decodes goto, sleep and halt frames and drives
 the target position and halt/sleep requests of the motion controller.
 assumes: link bytes and motion inputs come from logic on hclk.
*/
//Contract
// - goto frame: tag bits 5,4 set, eight bytes
// - identifier parity checked on reception
// - odd byte: pos high, marker one, address
// - signed 11-bit field applied on address match
// - goto only in half stepping mode
// - sleep: tag 0x3C, 0x00 then 0xFF
// - sleep taken regardless of node address
// - sleep in motion: secondary position or halt
// - halt ramps down to minimum, then stops
// - after halt, actual copied into target
// - halt ignored during two-point referencing
// - overtemperature raises an internal halt
// - halt frame: bit5 zero, 0x8F, selector+address
// - selector zero halts every node
// - master uses general two-byte pointer 0000
// - halt decoded from data bytes only; the code also requires identifier bit 5 zero and two data bytes
`timescale 1ns/100ps
`default_nettype none
module lmc_responder
   import lmc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   lmc_link_if.responder    link,
   input  wire logic [6:0]  node_address,
   input  wire logic [1:0]  stepping_selection,
   input  wire logic        motion_active,
   input  wire logic        two_point_referencing_sequence,
   input  wire logic        overtemp,
   input  wire logic [10:0] actual_position,
   input  wire logic [10:0] secondary_position,
   output logic      [10:0] target_position,
   output logic             halt_request,
   output logic             sleep_mode,
   output logic             frame_reject
);
   typedef enum logic [2:0] {
      S_RUN   = 3'b000,
      S_HALT  = 3'b001,
      S_SWAIT = 3'b010,
      S_SHALT = 3'b011,
      S_SLEEP = 3'b100
   } lmc_state_t;

   lmc_state_t  state_reg;
   lmc_state_t  state_next;
   logic [7:0]  tag_reg;
   logic [7:0]  data_reg [LMC_GOTO_LEN];
   logic [3:0]  cnt_reg;
   logic [7:0]  sum_reg;
   logic        eval_reg;
   logic        ok_reg;
   logic [3:0]  len_reg;
   logic        hot_reg;
   logic [10:0] target_reg;
   logic [10:0] target_next;
   logic        halt_reg;
   logic        reject_reg;
   logic        sleep_reg;

   // frame capture: identifier, data bytes, running checksum
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tag_reg  <= 8'h00;
         cnt_reg  <= 4'h0;
         sum_reg  <= 8'h00;
         eval_reg <= 1'b0;
         ok_reg   <= 1'b0;
         len_reg  <= 4'h0;
      end else begin
         eval_reg <= link.frm_valid && link.frm_last && !link.frm_first;
         if (link.frm_valid && link.frm_first) begin
            tag_reg <= link.frm_byte;
            cnt_reg <= 4'h0;
            sum_reg <= 8'h00;
         end else if (link.frm_valid && link.frm_last) begin
            len_reg <= cnt_reg;
            ok_reg  <= (link.frm_byte == ~sum_reg) && (cnt_reg != 4'h0)
                       && (lmc_tag(tag_reg[5:0]) == tag_reg);
         end else if (link.frm_valid && cnt_reg < 4'(LMC_GOTO_LEN)) begin
            cnt_reg <= cnt_reg + 4'h1;
            sum_reg <= lmc_add(sum_reg, link.frm_byte);
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < LMC_GOTO_LEN; gi++) begin : g_cap
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               data_reg[gi] <= 8'h00;
            end else if (link.frm_valid && !link.frm_first && !link.frm_last
                         && cnt_reg == 4'(gi)) begin
               data_reg[gi] <= link.frm_byte;
            end
         end
      end
   endgenerate

   // sleep pattern: first byte 0x00, every following byte 0xFF
   logic [LMC_GOTO_LEN-1:0] fill_ok;
   logic [3:0]              hit;
   logic [10:0]             hit_pos [4];
   generate
      for (gi = 0; gi < LMC_GOTO_LEN; gi++) begin : g_fill
         assign fill_ok[gi] = (gi == 0) || (4'(gi) >= len_reg)
                              || (data_reg[gi] == LMC_FILL);
      end
      for (gi = 0; gi < 4; gi++) begin : g_hit
         assign hit[gi] = data_reg[2*gi][LMC_MARK_BIT]
                          && data_reg[2*gi][3:0] == node_address[3:0];
         assign hit_pos[gi] = {data_reg[2*gi][7:5], data_reg[2*gi+1]};
      end
   endgenerate

   wire is_sleep = ok_reg && tag_reg == LMC_SLEEP_ID && len_reg >= 4'd2
                   && data_reg[0] == LMC_SLEEP_B1 && &fill_ok;
   // the sleep identifier also has bits 5,4 set; it must never move the motor
   wire is_goto  = ok_reg && tag_reg[5:4] == 2'b11 && tag_reg != LMC_SLEEP_ID
                   && len_reg == 4'(LMC_GOTO_LEN) && |hit
                   && stepping_selection == LMC_HALF_STEP;
   wire stop_frm = ok_reg && !tag_reg[5] && len_reg == 4'(LMC_STOP_LEN)
                   && data_reg[0] == LMC_STOP_CMD
                   && (!data_reg[1][LMC_BROAD_BIT]
                       || data_reg[1][6:0] == node_address);
   wire hot_rise = overtemp && !hot_reg;
   wire stop_req = ((eval_reg && stop_frm) || hot_rise)
                   && !two_point_referencing_sequence;
   wire sec_ok   = secondary_position != LMC_NO_SECONDARY_POSITION;
   wire [10:0] goto_pos = hit[0] ? hit_pos[0] : hit[1] ? hit_pos[1]
                        : hit[2] ? hit_pos[2] : hit_pos[3];

   always_comb begin
      state_next  = state_reg;
      target_next = target_reg;
      case (state_reg)
         S_RUN, S_HALT: begin
            if (eval_reg && is_goto) begin
               target_next = goto_pos;
            end
            if (eval_reg && is_sleep) begin
               if (!motion_active) begin
                  state_next = S_SLEEP;
               end else if (sec_ok) begin
                  target_next = secondary_position;
                  state_next  = S_SWAIT;
               end else begin
                  state_next = S_SHALT;
               end
            end else if (stop_req && motion_active) begin
               state_next = S_HALT;
            end else if (state_reg == S_HALT && !motion_active) begin
               target_next = actual_position;
               state_next  = S_RUN;
            end
         end
         S_SWAIT: begin
            if (!motion_active) begin
               state_next = S_SLEEP;
            end
         end
         S_SHALT: begin
            if (!motion_active) begin
               target_next = actual_position;
               state_next  = S_SLEEP;
            end
         end
         S_SLEEP: begin
            if (link.frm_valid && link.frm_first) begin
               state_next = S_RUN;
            end
         end
         default: begin
            state_next = S_RUN;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg  <= S_RUN;
         target_reg <= LMC_POS_RST;
         hot_reg    <= 1'b0;
         halt_reg   <= 1'b0;
         reject_reg <= 1'b0;
         sleep_reg  <= 1'b0;
      end else begin
         state_reg  <= state_next;
         target_reg <= target_next;
         hot_reg    <= overtemp;
         halt_reg   <= state_next == S_HALT || state_next == S_SHALT;
         reject_reg <= eval_reg && !ok_reg;
         sleep_reg  <= state_next == S_SLEEP;
      end
   end

   assign target_position = target_reg;
   assign halt_request    = halt_reg;
   assign sleep_mode      = sleep_reg;
   assign frame_reject    = reject_reg;
endmodule
`default_nettype wire

//--- design/lmc_commander.sv
/*
 lmc_commander: master end; AHB-Lite register slave that builds goto,
 sleep and halt frames and sends them one byte per cycle on the link.
 assumes: single word transfers, one AHB-Lite master, hclk for both sides.
*/
`timescale 1ns/100ps
`default_nettype none
module lmc_commander
   import lmc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   lmc_link_if.commander    link
);
   logic [31:0] lo_reg;
   logic [31:0] hi_reg;
   logic [4:0]  tag_reg;
   logic [1:0]  kind_reg;
   logic        wr_reg;
   logic [7:0]  wa_reg;
   logic [31:0] rd_reg;
   logic        busy_reg;
   logic [3:0]  idx_reg;
   logic [3:0]  len_reg;
   logic [7:0]  sum_reg;
   logic [7:0]  fb_reg [LMC_GOTO_LEN+1];
   logic        v_reg;
   logic        f_reg;
   logic        l_reg;
   logic [7:0]  b_reg;

   // whole-word transfers only
   wire a_ok  = hsel && hready && htrans[1] && hsize == 3'h2;
   wire go    = wr_reg && wa_reg == LMC_CTRL_OFS && hwdata[LMC_GO_BIT] && !busy_reg;
   wire [1:0] k = hwdata[1:0];
   wire [63:0] raw = {hi_reg, lo_reg};
   wire [31:0] rd_next = haddr == LMC_CTRL_OFS ? {30'h0, kind_reg}
                       : haddr == LMC_TAG_OFS  ? {27'h0, tag_reg}
                       : haddr == LMC_LO_OFS   ? lo_reg
                       : haddr == LMC_HI_OFS   ? hi_reg
                       : haddr == LMC_STAT_OFS ? {31'h0, busy_reg} : 32'h0;

   // frame image built at the go write; byte i of raw is data byte i+1
   logic [7:0] img [LMC_GOTO_LEN+1];
   genvar gi;
   generate
      for (gi = 0; gi < LMC_GOTO_LEN; gi++) begin : g_img
         wire [7:0] rb = raw[8*gi +: 8];
         assign img[gi+1] = k == LMC_K_SLEEP ? (gi == 0 ? LMC_SLEEP_B1 : LMC_FILL)
                          : k == LMC_K_STOP  ? (gi == 0 ? LMC_STOP_CMD : rb)
                          : (gi % 2 == 0) ? (rb | 8'h10) : rb;
      end
   endgenerate
   assign img[0] = k == LMC_K_SLEEP ? LMC_SLEEP_ID
                 : k == LMC_K_STOP  ? lmc_tag({1'b0, tag_reg})
                 : lmc_tag({2'b11, tag_reg[3:0]});
   wire [3:0] len_go = k == LMC_K_STOP ? 4'(LMC_STOP_LEN) : 4'(LMC_GOTO_LEN);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_reg   <= 1'b0;
         wa_reg   <= 8'h00;
         rd_reg   <= LMC_REG_RST;
         lo_reg   <= LMC_REG_RST;
         hi_reg   <= LMC_REG_RST;
         tag_reg  <= 5'h00;
         kind_reg <= 2'h0;
      end else begin
         wr_reg <= a_ok && hwrite;
         wa_reg <= haddr;
         if (a_ok && !hwrite) begin
            rd_reg <= rd_next;
         end
         if (wr_reg && wa_reg == LMC_LO_OFS) begin
            lo_reg <= hwdata;
         end
         if (wr_reg && wa_reg == LMC_HI_OFS) begin
            hi_reg <= hwdata;
         end
         if (wr_reg && wa_reg == LMC_TAG_OFS) begin
            tag_reg <= hwdata[4:0];
         end
         if (go) begin
            kind_reg <= k;
         end
      end
   end

   generate
      for (gi = 0; gi <= LMC_GOTO_LEN; gi++) begin : g_fb
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               fb_reg[gi] <= 8'h00;
            end else if (go) begin
               fb_reg[gi] <= img[gi];
            end
         end
      end
   endgenerate

   // sender: identifier, data bytes, then the inverted carry sum
   wire at_sum = idx_reg == len_reg + 4'h1;
   // past a goto or sleep checksum the index runs beyond the image and the idle byte is zero; after a halt frame it repeats image byte 4
   wire in_img = idx_reg <= 4'(LMC_GOTO_LEN);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_reg <= 1'b0;
         idx_reg  <= 4'h0;
         len_reg  <= 4'h0;
         sum_reg  <= 8'h00;
         v_reg    <= 1'b0;
         f_reg    <= 1'b0;
         l_reg    <= 1'b0;
         b_reg    <= 8'h00;
      end else begin
         v_reg <= busy_reg;
         f_reg <= busy_reg && idx_reg == 4'h0;
         l_reg <= busy_reg && at_sum;
         b_reg <= at_sum ? ~sum_reg : in_img ? fb_reg[idx_reg] : 8'h00;
         if (go) begin
            busy_reg <= 1'b1;
            idx_reg  <= 4'h0;
            len_reg  <= len_go;
            sum_reg  <= 8'h00;
         end else if (busy_reg) begin
            idx_reg  <= idx_reg + 4'h1;
            busy_reg <= !at_sum;
            if (idx_reg != 4'h0 && !at_sum) begin
               sum_reg <= lmc_add(sum_reg, fb_reg[idx_reg]);
            end
         end
      end
   end

   assign hrdata         = rd_reg;
   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;
   assign link.frm_valid = v_reg;
   assign link.frm_first = f_reg;
   assign link.frm_last  = l_reg;
   assign link.frm_byte  = b_reg;
endmodule
`default_nettype wire

//--- tb/lmc_link_props.sv
/*
 lmc_link_props: checks on the byte stream between commander and responder.
 assumes: instantiated beside the link interface; everything on hclk.
*/
`timescale 1ns/100ps
`default_nettype none
module lmc_link_props (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       frm_valid,
   input wire logic       frm_first,
   input wire logic       frm_last,
   input wire logic [7:0] frm_byte
);
   logic [3:0] idx_reg;
   logic [5:0] tag_reg;
   logic [7:0] sum_reg;
   logic [8:0] sum_wide;
   wire        data_byte = frm_valid && !frm_first && !frm_last;
   wire        long_tag  = tag_reg[5:4] == 2'h3;
   wire        sleep_tag = tag_reg == 6'h3C;
   assign sum_wide = {1'b0, sum_reg} + {1'b0, frm_byte};
   // idx_reg numbers the data bytes from 1, sum_reg runs the end-around sum
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx_reg <= 4'h0;
         tag_reg <= 6'h00;
         sum_reg <= 8'h00;
      end else if (frm_valid && frm_first) begin
         idx_reg <= 4'h1;
         tag_reg <= frm_byte[5:0];
         sum_reg <= 8'h00;
      end else if (data_byte) begin
         idx_reg <= idx_reg + 4'h1;
         sum_reg <= sum_wide[7:0] + {7'h00, sum_wide[8]};
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_tag_parity: assert property (
      frm_valid && frm_first |-> frm_byte[6] == ^{frm_byte[4], frm_byte[2:0]}
      && frm_byte[7] == ~^{frm_byte[5:3], frm_byte[1]}) else $error("bad tag parity");
   a_frame_len: assert property (
      frm_valid && frm_last |-> idx_reg == (tag_reg[5] ? 4'h9 : 4'h3))
      else $error("wrong frame length");
   a_odd_mark: assert property (
      data_byte && long_tag && !sleep_tag && idx_reg[0] |-> frm_byte[4])
      else $error("odd byte marker missing");
   a_halt_code: assert property (
      data_byte && !tag_reg[5] && idx_reg == 4'h1 |-> frm_byte == 8'h8F)
      else $error("halt code wrong");
   a_sleep_fill: assert property (
      data_byte && sleep_tag |-> frm_byte == (idx_reg == 4'h1 ? 8'h00 : 8'hFF))
      else $error("sleep data wrong");
   a_check_sum: assert property (
      frm_valid && frm_last |-> frm_byte == ~sum_reg) else $error("checksum wrong");
   a_idle_quiet: assert property (
      !frm_valid |-> !frm_first && !frm_last) else $error("marker outside frame");
   a_byte_stream: assert property (
      frm_valid && !frm_last |=> frm_valid && !frm_first) else $error("frame broken");
endmodule
`default_nettype wire

//--- tb/lin_motion_command_decoder_tb.sv
/*
 lin_motion_command_decoder_tb: commander and responder joined by the link,
 driven over AHB-Lite; a second responder takes broken frames from the bench.
 assumes: design files compiled first; one clock hclk.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin error_cnt++; \
   $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module lin_motion_command_decoder_tb
   import lmc_pkg::*;
;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b1;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hready, hresp, halt, slp, rej, rej2, rej_seen, rej1_seen;
   logic [6:0]  node = 7'h00;
   logic [1:0]  step = 2'h0;
   logic        motion = 1'b0, refr = 1'b0, otemp = 1'b0;
   logic [10:0] act = 11'h000, sec = 11'h400, tgt, tgt2, tgt_m;
   logic [31:0] seed = 32'd94;
   int          error_cnt = 0, n_checks = 0;
   lmc_link_if link ();
   lmc_link_if link2 ();
   lmc_commander lmc_commander_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .link(link.commander));
   lmc_responder lmc_responder_i (.hclk(hclk), .hresetn(hresetn), .link(link.responder),
      .node_address(node), .stepping_selection(step), .motion_active(motion),
      .two_point_referencing_sequence(refr), .overtemp(otemp), .actual_position(act),
      .secondary_position(sec), .target_position(tgt), .halt_request(halt),
      .sleep_mode(slp), .frame_reject(rej));
   lmc_responder lmc_responder_i2 (.hclk(hclk), .hresetn(hresetn), .link(link2.responder),
      .node_address(node), .stepping_selection(step), .motion_active(motion),
      .two_point_referencing_sequence(refr), .overtemp(otemp), .actual_position(act),
      .secondary_position(sec), .target_position(tgt2), .halt_request(),
      .sleep_mode(), .frame_reject(rej2));
   lmc_link_props lmc_link_props_i (.hclk(hclk), .hresetn(hresetn), .frm_valid(link.frm_valid),
      .frm_first(link.frm_first), .frm_last(link.frm_last), .frm_byte(link.frm_byte));
   initial forever #50 hclk = ~hclk;
   always @(posedge hclk) begin
      if (rej2 === 1'b1) rej_seen <= 1'b1;
      if (rej === 1'b1) rej1_seen <= 1'b1;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // first matching motor field wins
   function automatic logic [10:0] exp_goto(input logic [63:0] d, input logic [3:0] a,
                                            input logic [10:0] old);
      logic [10:0] r;
      r = old;
      for (int m = 3; m >= 0; m--) if (d[16*m+:4] == a) r = {d[16*m+5+:3], d[16*m+8+:8]};
      return r;
   endfunction
   function automatic logic [7:0] csum(input logic [63:0] d, input int n);
      logic [8:0] s;
      s = 9'h000;
      for (int j = 0; j < n; j++) begin
         s = {1'b0, s[7:0]} + {1'b0, d[8*j+:8]};
         s = {1'b0, s[7:0]} + {8'h00, s[8]};
      end
      return ~s[7:0];
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_rdy();
      int k;
      k = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         k++;
         if (k > 50) begin error_cnt++; final_report(); end
         @(posedge hclk);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      `CHK("okay", 1'b0, hresp)
   endtask
   task automatic cmd(input logic [1:0] kind, input logic [4:0] tag, input logic [63:0] d);
      logic [31:0] r;
      int k;
      ahb(1'b1, LMC_TAG_OFS, {27'h0, tag}, r);
      ahb(1'b1, LMC_LO_OFS, d[31:0], r);
      ahb(1'b1, LMC_HI_OFS, d[63:32], r);
      ahb(1'b1, LMC_CTRL_OFS, {29'h0, 1'b1, kind}, r);
      r = 32'h1;
      for (k = 0; k < 40 && r[0] === 1'b1; k++) ahb(1'b0, LMC_STAT_OFS, 32'h0, r);
      if (r[0] !== 1'b0) begin error_cnt++; final_report(); end
      repeat (4) @(posedge hclk);
   endtask
   // raw frame on the second link; flip spoils the checksum
   task automatic send_raw(input logic [7:0] id, input logic [63:0] d, input int n,
                           input logic [7:0] flip);
      @(posedge hclk);
      link2.frm_valid <= 1'b1;
      link2.frm_first <= 1'b1;
      link2.frm_byte <= id;
      for (int j = 0; j < n; j++) begin
         @(posedge hclk);
         link2.frm_first <= 1'b0;
         link2.frm_byte <= d[8*j+:8];
      end
      @(posedge hclk);
      link2.frm_last <= 1'b1;
      link2.frm_byte <= csum(d, n) ^ flip;
      @(posedge hclk);
      link2.frm_valid <= 1'b0;
      link2.frm_last <= 1'b0;
      link2.frm_byte <= ~link2.frm_byte;
      repeat (4) @(posedge hclk);
   endtask
   initial begin
      logic [63:0] d;
      logic [31:0] r;
      logic [10:0] e;
      logic [6:0]  nd;
      logic [4:0]  t;
      link2.frm_valid = 1'b0;
      link2.frm_first = 1'b0;
      link2.frm_last = 1'b0;
      link2.frm_byte = 8'h00;
      rej_seen = 1'b0;
      rej1_seen = 1'b0;
      tgt_m = LMC_POS_RST;
      repeat (20) @(posedge hclk);
      `CHK("halt rst", 1'b0, halt)
      `CHK("sleep rst", 1'b0, slp)
      hresetn <= 1'b1;
      ahb(1'b1, 8'h20, 32'hFFFF_FFFF, r);
      ahb(1'b0, 8'h20, 32'h0, r);
      `CHK("unmapped", 32'h0, r)
      for (int i = 0; i < 9; i++) begin
         d = {xs(), xs()};
         nd = 7'(xs());
         if (i < 6) d[16*(i%4)+:4] = nd[3:0];
         if (i == 1) d[31:16] = {8'h00, 3'h4, 1'b1, nd[3:0]};
         if (i == 2) d[47:32] = {8'hFF, 3'h3, 1'b1, nd[3:0]};
         node <= nd;
         step <= (i < 6) ? 2'h0 : 2'(i - 5);
         if (i < 6) tgt_m = exp_goto(d, nd[3:0], tgt_m);
         t = 5'(xs());
         if (t[3:0] == 4'hC) t = t ^ 5'h01;
         cmd(LMC_K_GOTO, t, d);
         `CHK("goto target", tgt_m, tgt)
      end
      $display("test goto done");
      step <= 2'h0;
      for (int i = 0; i < 3; i++) begin
         e = 11'(xs()) & 11'h3FF;
         act <= e ^ 11'h155;
         motion <= (i > 0);
         sec <= (i == 1) ? e : LMC_NO_SECONDARY_POSITION;
         node <= 7'(xs());
         cmd(LMC_K_SLEEP, 5'h00, {{7{8'hFF}}, 8'h00});
         if (i == 0) `CHK("sleep", 1'b1, slp)
         if (i == 1) `CHK("sec target", e, tgt)
         if (i == 2) `CHK("sleep halt", 1'b1, halt)
         motion <= 1'b0;
         repeat (4) @(posedge hclk);
      end
      $display("test sleep done");
      for (int i = 0; i < 4; i++) begin
         e = 11'(xs());
         act <= e;
         motion <= 1'b1;
         refr <= (i == 3);
         d = {48'h0, (i == 1 || i == 2), (i == 1) ? node : node ^ 7'h01, 8'h00};
         cmd(LMC_K_STOP, 5'(xs()), d);
         `CHK("halt", (i < 2), halt)
         repeat (3) @(posedge hclk);
         `CHK("halt held", (i < 2), halt)
         motion <= 1'b0;
         repeat (4) @(posedge hclk);
         if (i < 2) `CHK("hold stop", e, tgt)
      end
      refr <= 1'b0;
      motion <= 1'b1;
      otemp <= 1'b1;
      repeat (4) @(posedge hclk);
      `CHK("hot halt", 1'b1, halt)
      otemp <= 1'b0;
      motion <= 1'b0;
      $display("test halt done");
      node <= 7'h05;
      e = 11'(xs());
      d = {48'h0, e[7:0], e[10:8], 1'b1, 4'h5};
      send_raw(8'hB1, d, 8, 8'h00);
      `CHK("raw goto", e, tgt2)
      for (int i = 0; i < 3; i++) begin
         rej_seen = 1'b0;
         send_raw(i == 1 ? 8'h71 : 8'hB1, d ^ 64'hFF00, i == 2 ? 6 : 8, i == 0 ? 8'h01 : 8'h00);
         // a short frame is ignored without a reject pulse
         `CHK("reject", (i != 2), rej_seen)
         `CHK("kept", e, tgt2)
      end
      `CHK("good frames", 1'b0, rej1_seen)
      $display("test broken frames done");
      final_report();
   end
endmodule
`default_nettype wire
